// *** hw/fsrr_top.sv ***
// Serial status register read engine of the flash device
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Opcode 05h after chip select selects first status register for output.
// - Opcode 35h selects second status register for output.
// - Opcode 15h selects third status register for output.
// - After bit 0, output restarts at bit 7 while selected and clocked.
// - Each repeated byte is a fresh sample of the live register.
// - Chip select release ends the read and floats serial output.
// - Chip select may be released at any bit position.
// - Status reads are served even while an internal operation runs.
// - First register: guard0, size, top/bottom, level2..0, write latch, busy.
// - Write latch is read-only, resets to 0, reads 1 when enabled.
// - Busy flag is read-only, 1 while an internal operation runs.
// - Status writes change only writable bits; read-only bits stay hardware-driven.
// - Second register bit 7 shows erase suspended, read-only.
// - Second register bit 2 shows program suspended, read-only.
// - Second register bit 6 inverts protection, writable, resets 0.
// - Second register bits 5..3 lock security pages 3..1.
// - Second register bit 1 turns pause and guard pins into data pins.
// - Second register bit 0 is writable guard bit 1.
// - Third register bits 6:5 choose output strength, reset 11.
// - Guard 00 allows writes, 01 blocks on low pin, 10 locks.
// - Write latch clears on reset and on write, program or erase end.
module fsrr_top
  import fsrr_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  input wire logic write_guard_pin_n,
  input wire logic busy_in,
  input wire logic erase_paused_in,
  input wire logic program_paused_in,
  input wire logic latch_set,
  input wire logic latch_clr,
  input wire logic wsr_req,
  input wire logic [1:0] wsr_sel,
  input wire logic [7:0] wsr_data,
  output logic write_latch,
  output logic busy_flag,
  output logic [1:0] sr_guard,
  output logic prot_size_select,
  output logic prot_top_bottom,
  output logic [2:0] prot_level,
  output logic protect_invert,
  output logic [2:0] page_lock,
  output logic quad_io_enable,
  output logic [1:0] output_strength,
  output logic status_write_ok
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic guard_pin_s;

  // Reset to the idle pin levels so no frame seems to start as reset lifts
  fsrr_sync #(.WIDTH(4), .RST_VAL(FSRR_PIN_RST)) u_sync
  (
    .mclk(mclk),
    .nrst(nrst),
    .din({sck, cs_n, si, write_guard_pin_n}),
    .dout(pins_s)
  );

  // Guard pin is active low: in guard 01, low means writes are held off
  assign sck_s = pins_s[3];
  assign cs_n_s = pins_s[2];
  assign si_s = pins_s[1];
  assign guard_pin_s = pins_s[0];

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [7:0] sr1;
  logic [7:0] sr2;
  logic [7:0] sr3;

  fsrr_regs u_regs
  (
    .mclk(mclk),
    .nrst(nrst),
    .busy_in(busy_in),
    .erase_paused_in(erase_paused_in),
    .program_paused_in(program_paused_in),
    .latch_set(latch_set),
    .latch_clr(latch_clr),
    .guard_pin_s(guard_pin_s),
    .wsr_req(wsr_req),
    .wsr_sel(wsr_sel),
    .wsr_data(wsr_data),
    .sr1(sr1),
    .sr2(sr2),
    .sr3(sr3),
    .write_latch(write_latch),
    .guard(sr_guard),
    .write_ok(status_write_ok)
  );

  // Field views for the rest of the device
  assign busy_flag = sr1[FSRR_SR1_BUSY];
  assign prot_size_select = sr1[FSRR_SR1_PROT_HI];
  assign prot_top_bottom = sr1[FSRR_SR1_PROT_HI-1];
  assign prot_level = sr1[FSRR_SR1_PROT_LO+2:FSRR_SR1_PROT_LO];
  assign protect_invert = sr2[FSRR_SR2_INVERT];
  assign page_lock = sr2[FSRR_SR2_LOCK_HI:FSRR_SR2_LOCK_LO];
  assign quad_io_enable = sr2[FSRR_SR2_QUAD];
  assign output_strength = sr3[FSRR_SR3_DRV_HI:FSRR_SR3_DRV_LO];

  // ----------------------------------------------------------------
  // Serial clock edge detection
  // ----------------------------------------------------------------
  logic sck_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_act;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      sck_q <= 1'b0;
    else
      sck_q <= sck_s;
  end

  // Works for both idle clock levels since only edges count
  assign sck_rise = sck_s & ~sck_q;
  assign sck_fall = ~sck_s & sck_q;
  assign cs_act = ~cs_n_s;

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  fsrr_state_t state;
  fsrr_state_t next_state;
  logic [6:0] op_shift;
  logic [6:0] next_op_shift;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [1:0] sel;
  logic [1:0] next_sel;
  logic [7:0] snap;
  logic [7:0] next_snap;
  logic [2:0] out_idx;
  logic [2:0] next_out_idx;
  logic next_so_out;
  logic [7:0] full_op;
  logic [7:0] live_byte;
  logic [7:0] cur_byte;

  assign full_op = {op_shift, si_s};

  // Live contents of the selected register
  always_comb
  begin
    if (sel == FSRR_SEL_SR1)
      live_byte = sr1;
    else if (sel == FSRR_SEL_SR2)
      live_byte = sr2;
    else if (sel == FSRR_SEL_SR3)
      live_byte = sr3;
    else
      live_byte = 8'h00;
  end

  // Fresh sample at every byte start, held for the rest of the byte
  assign cur_byte = (out_idx == 3'h7) ? live_byte : snap;

  // Next-state logic; no busy term, reads never wait on internal work
  always_comb
  begin
    next_state = state;
    next_op_shift = op_shift;
    next_bit_cnt = bit_cnt;
    next_sel = sel;
    next_snap = snap;
    next_out_idx = out_idx;
    next_so_out = so_out;
    if (!cs_act)
    begin
      // Release at any bit ends the read at once
      next_state = FSRR_IDLE;
      next_bit_cnt = 3'h0;
      next_sel = FSRR_SEL_NONE;
      next_out_idx = 3'h7;
      next_so_out = 1'b0;
    end
    else
    begin
      case (state)
        FSRR_IDLE:
        begin
          next_state = FSRR_OPCODE;
          next_bit_cnt = 3'h0;
        end
        FSRR_OPCODE:
        begin
          if (sck_rise)
          begin
            next_op_shift = full_op[6:0];
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
              next_out_idx = 3'h7;
              next_state = FSRR_SEND;
              if (full_op == FSRR_OP_READ_SR1)
                next_sel = FSRR_SEL_SR1;
              else if (full_op == FSRR_OP_READ_SR2)
                next_sel = FSRR_SEL_SR2;
              else if (full_op == FSRR_OP_READ_SR3)
                next_sel = FSRR_SEL_SR3;
              else
                next_state = FSRR_IGNORE;
            end
          end
        end
        FSRR_SEND:
        begin
          if (sck_fall)
          begin
            next_so_out = cur_byte[out_idx];
            next_snap = cur_byte;
            next_out_idx = out_idx - 3'h1;
          end
        end
        FSRR_IGNORE:
        begin
          next_state = FSRR_IGNORE;
        end
        default:
        begin
          next_state = FSRR_IDLE;
        end
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= FSRR_IDLE;
      op_shift <= 7'h00;
      bit_cnt <= 3'h0;
      sel <= FSRR_SEL_NONE;
      snap <= 8'h00;
      out_idx <= 3'h7;
      so_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      op_shift <= next_op_shift;
      bit_cnt <= next_bit_cnt;
      sel <= next_sel;
      snap <= next_snap;
      out_idx <= next_out_idx;
      so_out <= next_so_out;
    end
  end

  // Drive only while streaming; high impedance otherwise
  assign so_oe = (state == FSRR_SEND);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic opc_done;
  assign opc_done = (state == FSRR_OPCODE) && cs_act && sck_rise && (bit_cnt == 3'h7);

  a_release_floats: assert property (!cs_act |=> !so_oe)
    else $error("output driven after release");
  a_release_any_bit: assert property (state == FSRR_SEND && !cs_act |=> state == FSRR_IDLE)
    else $error("read not ended on release");
  a_read_sr1: assert property (opc_done && full_op == FSRR_OP_READ_SR1 |=> so_oe && sel == FSRR_SEL_SR1)
    else $error("opcode 05 not served");
  a_read_sr2: assert property (opc_done && full_op == FSRR_OP_READ_SR2 |=> so_oe && sel == FSRR_SEL_SR2)
    else $error("opcode 35 not served");
  a_read_sr3: assert property (opc_done && full_op == FSRR_OP_READ_SR3 |=> so_oe && sel == FSRR_SEL_SR3)
    else $error("opcode 15 not served");
  a_busy_served: assert property (opc_done && busy_in && full_op == FSRR_OP_READ_SR1 |=> state == FSRR_SEND)
    else $error("read refused while busy");
  a_wrap_to_msb: assert property (state == FSRR_SEND && cs_act && sck_fall && out_idx == 3'h0 |=> out_idx == 3'h7)
    else $error("bit index did not wrap");
  a_fresh_msb: assert property (state == FSRR_SEND && cs_act && sck_fall && out_idx == 3'h7
                                |=> so_out == $past(live_byte[7]) && snap == $past(live_byte))
    else $error("byte not freshly sampled");
  a_bit_order: assert property (state == FSRR_SEND && cs_act && sck_fall && out_idx != 3'h7
                                |=> so_out == $past(snap[out_idx]))
    else $error("bit order wrong");
  a_sr3_reserved: assert property (state == FSRR_SEND && cs_act && sck_fall && sel == FSRR_SEL_SR3
                                   && (out_idx == 3'h7 || out_idx <= 3'h4) |=> !so_out)
    else $error("reserved bits nonzero");

  c_read_sr1: cover property (opc_done && full_op == FSRR_OP_READ_SR1);
  c_read_sr3: cover property (opc_done && full_op == FSRR_OP_READ_SR3);
  c_wrap: cover property (state == FSRR_SEND && sck_fall && out_idx == 3'h0 ##[1:200] sck_fall);
  c_mid_release: cover property (state == FSRR_SEND && out_idx == 3'h3 && !cs_act);

endmodule : fsrr_top

`default_nettype wire

// *** hw/fsrr_pkg.sv ***
// Shared constants for the flash status register read block
package fsrr_pkg;

  // ----------------------------------------------------------------
  // Read opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] FSRR_OP_READ_SR1 = 8'h05;
  localparam logic [7:0] FSRR_OP_READ_SR2 = 8'h35;
  localparam logic [7:0] FSRR_OP_READ_SR3 = 8'h15;

  // ----------------------------------------------------------------
  // Register selection codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FSRR_SEL_NONE = 2'h0;
  localparam logic [1:0] FSRR_SEL_SR1 = 2'h1;
  localparam logic [1:0] FSRR_SEL_SR2 = 2'h2;
  localparam logic [1:0] FSRR_SEL_SR3 = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FSRR_SR1_GUARD0 = 7;
  localparam int FSRR_SR1_PROT_HI = 6;
  localparam int FSRR_SR1_PROT_LO = 2;
  localparam int FSRR_SR1_LATCH = 1;
  localparam int FSRR_SR1_BUSY = 0;
  localparam int FSRR_SR2_ERASE_P = 7;
  localparam int FSRR_SR2_INVERT = 6;
  localparam int FSRR_SR2_LOCK_HI = 5;
  localparam int FSRR_SR2_LOCK_LO = 3;
  localparam int FSRR_SR2_PROG_P = 2;
  localparam int FSRR_SR2_QUAD = 1;
  localparam int FSRR_SR2_GUARD1 = 0;
  localparam int FSRR_SR3_DRV_HI = 6;
  localparam int FSRR_SR3_DRV_LO = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] FSRR_PROT_RST = 5'h00;
  localparam logic [2:0] FSRR_LOCK_RST = 3'h0;
  localparam logic [1:0] FSRR_DRV_RST = 2'h3;
  localparam logic [1:0] FSRR_GUARD_RST = 2'h0;
  // Pin synchroniser idle {sck, cs_n, si, write_guard_pin_n}: chip select and guard pin inactive
  localparam logic [3:0] FSRR_PIN_RST = 4'h5;

  // ----------------------------------------------------------------
  // Guard encodings {sr_guard_1, sr_guard_0}
  // ----------------------------------------------------------------
  localparam logic [1:0] FSRR_GUARD_SOFT = 2'h0;
  localparam logic [1:0] FSRR_GUARD_PIN = 2'h1;
  localparam logic [1:0] FSRR_GUARD_LOCKDOWN = 2'h2;

  // ----------------------------------------------------------------
  // Serial engine states
  // ----------------------------------------------------------------
  typedef enum logic [3:0]
  {
    FSRR_IDLE = 4'b0001,
    FSRR_OPCODE = 4'b0010,
    FSRR_SEND = 4'b0100,
    FSRR_IGNORE = 4'b1000
  } fsrr_state_t;

endpackage : fsrr_pkg

// *** hw/fsrr_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module fsrr_sync
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : fsrr_sync

`default_nettype wire

// *** hw/fsrr_regs.sv ***
// Status register bank: writable fields, latch and live hardware flags
`timescale 1ns/100ps
`default_nettype none

module fsrr_regs
  import fsrr_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic busy_in,
  input wire logic erase_paused_in,
  input wire logic program_paused_in,
  input wire logic latch_set,
  input wire logic latch_clr,
  input wire logic guard_pin_s,
  input wire logic wsr_req,
  input wire logic [1:0] wsr_sel,
  input wire logic [7:0] wsr_data,
  output logic [7:0] sr1,
  output logic [7:0] sr2,
  output logic [7:0] sr3,
  output logic write_latch,
  output logic [1:0] guard,
  output logic write_ok
);

  logic [4:0] prot;
  logic [4:0] next_prot;
  logic invert;
  logic next_invert;
  logic [2:0] locks;
  logic [2:0] next_locks;
  logic quad;
  logic next_quad;
  logic [1:0] drv;
  logic [1:0] next_drv;
  logic [1:0] next_guard;
  logic next_write_latch;

  // Write permitted only with latch set and guard open
  assign write_ok = wsr_req & write_latch & ((guard == FSRR_GUARD_SOFT) |
                    ((guard == FSRR_GUARD_PIN) & guard_pin_s));

  // Live images; read-only bits come straight from hardware
  assign sr1 = {guard[0], prot, write_latch, busy_in};
  assign sr2 = {erase_paused_in, invert, locks, program_paused_in, quad, guard[1]};
  assign sr3 = {1'b0, drv, 5'h00};

  // Next values: only writable fields take write data
  always_comb
  begin
    next_prot = prot;
    next_invert = invert;
    next_locks = locks;
    next_quad = quad;
    next_drv = drv;
    next_guard = guard;
    if (write_ok)
    begin
      if (wsr_sel == FSRR_SEL_SR1)
      begin
        next_guard[0] = wsr_data[FSRR_SR1_GUARD0];
        next_prot = wsr_data[FSRR_SR1_PROT_HI:FSRR_SR1_PROT_LO];
      end
      else if (wsr_sel == FSRR_SEL_SR2)
      begin
        next_invert = wsr_data[FSRR_SR2_INVERT];
        next_locks = wsr_data[FSRR_SR2_LOCK_HI:FSRR_SR2_LOCK_LO];
        next_quad = wsr_data[FSRR_SR2_QUAD];
        next_guard[1] = wsr_data[FSRR_SR2_GUARD1];
      end
      else if (wsr_sel == FSRR_SEL_SR3)
      begin
        next_drv = wsr_data[FSRR_SR3_DRV_HI:FSRR_SR3_DRV_LO];
      end
    end
    // Set wins so an enable racing a completion is not lost
    if (latch_set)
      next_write_latch = 1'b1;
    else if (latch_clr | wsr_req)
      next_write_latch = 1'b0;
    else
      next_write_latch = write_latch;
  end

  // Register stage; lockdown guard only leaves on reset (power cycle)
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      prot <= FSRR_PROT_RST;
      invert <= 1'b0;
      locks <= FSRR_LOCK_RST;
      quad <= 1'b0;
      drv <= FSRR_DRV_RST;
      guard <= FSRR_GUARD_RST;
      write_latch <= 1'b0;
    end
    else
    begin
      prot <= next_prot;
      invert <= next_invert;
      locks <= next_locks;
      quad <= next_quad;
      drv <= next_drv;
      guard <= next_guard;
      write_latch <= next_write_latch;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_latch_clears: assert property (latch_clr && !latch_set |=> !write_latch)
    else $error("write latch did not clear");
  a_lockdown_holds: assert property (guard == FSRR_GUARD_LOCKDOWN |=> $stable(guard) && $stable(prot))
    else $error("locked status changed");
  a_refused_holds: assert property (wsr_req && !write_ok |=> $stable(sr1[7:2]) && $stable(sr2[6:3])
                                    && $stable(sr2[1:0]) && $stable(sr3))
    else $error("refused write changed a field");

endmodule : fsrr_regs

`default_nettype wire

// *** tb/fsrr_host_model.sv ***
// SPI host model that issues status read frames to the device
`timescale 1ns/100ps
`default_nettype none

module fsrr_host_model
#(
  parameter int HALF_NS = 40
)
(
  output var logic sck,
  output var logic cs_n,
  output var logic si,
  input wire logic so
);

  // ----------------------------------------------------------------
  // Idle state
  // ----------------------------------------------------------------
  // Mode 0: the clock rests low and stands still between frames
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  // Opcode MSB first, then nbits answer bits; pause_ns stalls the clock after each answer byte
  task automatic read_frame(input logic [7:0] op, input int nbits, input int pause_ns, output logic [31:0] data);
    data = '0;
    cs_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      si = op[i];
      #(HALF_NS) sck = 1'b1;
      #(HALF_NS) sck = 1'b0;
    end
    for (int i = 0; i < nbits; i++)
    begin
      // Unused input keeps moving, so no stale level is mistaken for data
      si = ~si;
      #(HALF_NS) sck = 1'b1;
      data = {data[30:0], so};
      #(HALF_NS) sck = 1'b0;
      if (i % 8 == 7)
        #(pause_ns);
    end
    #(HALF_NS) cs_n = 1'b1;
    #(3 * HALF_NS);
  endtask : read_frame

endmodule : fsrr_host_model
`default_nettype wire

// *** tb/flash_status_register_read_tb.sv ***
// Self-checking bench for the status register read engine
`timescale 1ns/100ps
`default_nettype none

module flash_status_register_read_tb;
  import fsrr_pkg::*;

  logic mclk, nrst, sck, cs_n, si, so_out, so_oe, so_line;
  logic so_float = 1'b0;
  logic write_guard_pin_n, busy_in, erase_paused_in, program_paused_in;
  logic latch_set, latch_clr, wsr_req, write_latch, busy_flag;
  logic [1:0] wsr_sel, sr_guard, output_strength;
  logic [7:0] wsr_data;
  logic prot_size_select, prot_top_bottom, protect_invert, quad_io_enable, status_write_ok;
  logic [2:0] prot_level, page_lock;
  int err_count = 0;
  int num_checks = 0;
  int oe_cycles = 0;

  // ----------------------------------------------------------------
  // Clock, pin level and instances
  // ----------------------------------------------------------------
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  // Released output wanders, so a floating pin never reads as valid data
  always @(posedge mclk)
  begin
    so_float <= ~so_float;
    oe_cycles <= oe_cycles + ((so_oe === 1'b1) ? 1 : 0);
  end
  assign so_line = so_oe ? so_out : so_float;

  fsrr_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line));

  fsrr_top uut (.mclk(mclk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe),
    .write_guard_pin_n(write_guard_pin_n), .busy_in(busy_in), .erase_paused_in(erase_paused_in),
    .program_paused_in(program_paused_in), .latch_set(latch_set), .latch_clr(latch_clr), .wsr_req(wsr_req),
    .wsr_sel(wsr_sel), .wsr_data(wsr_data), .write_latch(write_latch), .busy_flag(busy_flag),
    .sr_guard(sr_guard), .prot_size_select(prot_size_select), .prot_top_bottom(prot_top_bottom),
    .prot_level(prot_level), .protect_invert(protect_invert), .page_lock(page_lock),
    .quad_io_enable(quad_io_enable), .output_strength(output_strength), .status_write_ok(status_write_ok));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Full reset, then the settling time the synchronisers need
  task automatic do_reset;
    @(posedge mclk) #1 nrst = 1'b0;
    repeat (10) @(posedge mclk);
    #1 nrst = 1'b1;
    repeat (6) @(posedge mclk);
  endtask : do_reset

  // One frame; the pin must float once chip select is back high
  task automatic rd(input logic [7:0] op, input int nbits, input int pause, input logic [31:0] exp);
    logic [31:0] got;
    host.read_frame(op, nbits, pause, got);
    chk(got, exp);
    chk(so_oe, 1'b0);
  endtask : rd

  task automatic pulse_latch(input logic set, input logic clr);
    @(posedge mclk) #1;
    latch_set = set;
    latch_clr = clr;
    @(posedge mclk) #1;
    latch_set = 1'b0;
    latch_clr = 1'b0;
  endtask : pulse_latch

  // Optional write enable first; the latch always drops after the write
  task automatic wr(input logic [1:0] sel, input logic [7:0] d, input logic arm, input logic exp_ok);
    if (arm)
      pulse_latch(1'b1, 1'b0);
    chk(write_latch, arm);
    @(posedge mclk) #1;
    wsr_req = 1'b1;
    wsr_sel = sel;
    wsr_data = d;
    #1 chk(status_write_ok, exp_ok);
    @(posedge mclk) #1;
    wsr_req = 1'b0;
    chk(write_latch, 1'b0);
  endtask : wr

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_reset;
    rd(FSRR_OP_READ_SR1, 8, 0, 32'h00);
    rd(FSRR_OP_READ_SR2, 8, 0, 32'h00);
    rd(FSRR_OP_READ_SR3, 8, 0, 32'h60);
    chk(output_strength, 2'h3);
  endtask : s_reset

  // Busy rises between the first and second byte samples of one frame
  task automatic s_repeat;
    @(posedge mclk) #1;
    fork
      rd(FSRR_OP_READ_SR1, 24, 0, 32'h000101);
      #900 busy_in = 1'b1;
    join
    chk(busy_flag, 1'b1);
    rd(FSRR_OP_READ_SR1, 8, 0, 32'h01);
    @(posedge mclk) #1 busy_in = 1'b0;
  endtask : s_repeat

  task automatic s_latch;
    pulse_latch(1'b1, 1'b0);
    rd(FSRR_OP_READ_SR1, 8, 0, 32'h02);
    pulse_latch(1'b0, 1'b1);
    chk(write_latch, 1'b0);
  endtask : s_latch

  task automatic s_write;
    wr(FSRR_SEL_SR3, 8'h20, 1'b1, 1'b1);
    rd(FSRR_OP_READ_SR3, 8, 0, 32'h20);
    wr(FSRR_SEL_SR2, 8'hfa, 1'b1, 1'b1);
    rd(FSRR_OP_READ_SR2, 8, 0, 32'h7a);
    chk({protect_invert, page_lock, quad_io_enable}, 5'h1f);
    @(posedge mclk) #1;
    erase_paused_in = 1'b1;
    program_paused_in = 1'b1;
    rd(FSRR_OP_READ_SR2, 16, 200, 32'hfefe);
    @(posedge mclk) #1;
    erase_paused_in = 1'b0;
    program_paused_in = 1'b0;
    wr(FSRR_SEL_SR2, 8'h00, 1'b1, 1'b1);
    wr(FSRR_SEL_SR1, 8'h7c, 1'b0, 1'b0);
    rd(FSRR_OP_READ_SR1, 8, 0, 32'h00);
    wr(FSRR_SEL_SR1, 8'hff, 1'b1, 1'b1);
    rd(FSRR_OP_READ_SR1, 8, 0, 32'hfc);
    chk({sr_guard, prot_size_select, prot_top_bottom, prot_level}, 7'h3f);
  endtask : s_write

  task automatic s_guard;
    logic [31:0] got;
    int snap;
    @(posedge mclk) #1 write_guard_pin_n = 1'b0;
    wr(FSRR_SEL_SR1, 8'h00, 1'b1, 1'b0);
    @(posedge mclk) #1 write_guard_pin_n = 1'b1;
    wr(FSRR_SEL_SR1, 8'h40, 1'b1, 1'b1);
    wr(FSRR_SEL_SR2, 8'h01, 1'b1, 1'b1);
    chk(sr_guard, FSRR_GUARD_LOCKDOWN);
    wr(FSRR_SEL_SR3, 8'h60, 1'b1, 1'b0);
    chk(output_strength, 2'h1);
    snap = oe_cycles;
    host.read_frame(8'h9f, 8, 0, got);
    chk(oe_cycles - snap, 0);
    rd(FSRR_OP_READ_SR1, 3, 0, 32'h2);
    rd(FSRR_OP_READ_SR1, 8, 0, 32'h40);
    do_reset();
    chk({sr_guard, output_strength}, 4'h3);
    rd(FSRR_OP_READ_SR2, 8, 0, 32'h00);
  endtask : s_guard

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    write_guard_pin_n = 1'b1;
    busy_in = 1'b0;
    erase_paused_in = 1'b0;
    program_paused_in = 1'b0;
    latch_set = 1'b0;
    latch_clr = 1'b0;
    wsr_req = 1'b0;
    wsr_sel = 2'h0;
    wsr_data = 8'h00;
    do_reset();
    s_reset();
    s_repeat();
    s_latch();
    s_write();
    s_guard();
    stop_test();
  end

  initial
  begin
    #400000;
    err_count++;
    $display("mismatch at %0t: run did not finish in time", $time);
    stop_test();
  end

endmodule : flash_status_register_read_tb
`default_nettype wire
